// [dv/rcr_checker.sv]
// Port checker for the reset cause recorder.
// Assumes it is bound to rcr_top and sees only that module's ports.
`timescale 1ns/100ps
module rcr_checker #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register bus.
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   // Event sources.
   input wire logic brownout_in,
   input wire logic master_clear_pin_n_in,
   input wire logic wdt_timeout_in,
   input wire logic reset_instr_in,
   input wire logic interrupt_wake_in,
   // Core side.
   input wire logic sleeping_in,
   input wire logic [WIDTH-1:0] pc_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic jump_out,
   input wire logic reset_core_out,
   input wire logic [WIDTH-1:0] jump_addr_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Higher-priority causes that would mask a wake in the same cycle.
   wire quiet = !reset_instr_in && !push_in && !pop_in;
   sequence s_restart;
      jump_out && reset_core_out && jump_addr_out == '0;
   endsequence
   sequence s_resume(logic [WIDTH-1:0] tgt);
      jump_out && !reset_core_out && jump_addr_out == tgt;
   endsequence
   a_power_on: assert property (disable iff (1'b0) !rst_n_in |=> s_restart)
      else $error("no restart after power-on reset");
   a_wdt_restart: assert property (wdt_timeout_in && !sleeping_in |=> s_restart)
      else $error("watchdog reset did not restart at zero");
   a_instr_restart: assert property (reset_instr_in |=> s_restart)
      else $error("reset instruction did not restart at zero");
   a_wdt_wake: assert property (wdt_timeout_in && sleeping_in && quiet
      |=> s_resume($past(pc_in) + 1'b1)) else $error("watchdog wake did not resume");
   a_int_wake: assert property (interrupt_wake_in && sleeping_in && quiet
      && !wdt_timeout_in |=> s_resume($past(pc_in) + 1'b1))
      else $error("interrupt wake did not resume");
   a_pin_restart: assert property ($fell(master_clear_pin_n_in) |-> ##[1:5] s_restart)
      else $error("pin reset did not restart at zero");
   a_bor_restart: assert property ($rose(brownout_in) |-> ##[1:5] s_restart)
      else $error("brown-out did not restart at zero");
   a_core_pair: assert property (reset_core_out |-> jump_out)
      else $error("core reset without jump");
   a_wait_once: assert property ($rose(avs_read_in || avs_write_in)
      |-> avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bad wait cycle");
endmodule

bind rcr_top rcr_checker #(.WIDTH(WIDTH), .DEPTH(DEPTH)) chk (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
   .brownout_in(brownout_in), .master_clear_pin_n_in(master_clear_pin_n_in),
   .wdt_timeout_in(wdt_timeout_in), .reset_instr_in(reset_instr_in),
   .interrupt_wake_in(interrupt_wake_in), .sleeping_in(sleeping_in), .pc_in(pc_in),
   .push_in(push_in), .pop_in(pop_in), .jump_out(jump_out),
   .reset_core_out(reset_core_out), .jump_addr_out(jump_addr_out));

// [dv/rcr_core_model.sv]
// Behavioural processor core facing the recorder.
// Assumes registered jump and pop pulses on the same clock.
`timescale 1ns/100ps
module rcr_core_model (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Recorder side.
   input wire logic jump_in,
   input wire logic reset_core_in,
   input wire logic [14:0] jump_addr_in,
   input wire logic pop_valid_in,
   input wire logic [14:0] pop_data_in,
   // Core state.
   output logic instr_done_out,
   output logic [14:0] pc_out,
   output logic [14:0] last_pop_out,
   output logic last_reset_out,
   output int jump_cnt_out
);
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         instr_done_out <= 1'b0;
         pc_out <= 15'h0000;
         last_reset_out <= 1'b0;
         jump_cnt_out <= 0;
      end else begin
         // A resumed core runs one instruction right away.
         instr_done_out <= jump_in && !reset_core_in;
         if (jump_in) begin
            pc_out <= jump_addr_in;
            last_reset_out <= reset_core_in;
            jump_cnt_out <= jump_cnt_out + 1;
         end else if (instr_done_out) begin
            pc_out <= pc_out + 15'h0001;
         end
         if (pop_valid_in) begin
            last_pop_out <= pop_data_in;
         end
      end
   end
endmodule

// [dv/reset_cause_recorder_bench.sv]
// Self-checking bench for the reset cause recorder.
// Assumes rcr_top, the core model and the bound checker.
`timescale 1ns/100ps
`include "rcr_cfg.svh"
module reset_cause_recorder_bench;
   typedef struct packed {
      logic [2:0] ev;
      logic slp;
      logic [31:0] st;
      logic [31:0] pw;
      logic rs;
   } rcr_row_t;
   // Event kinds: brown-out, watchdog, pin, reset instruction, interrupt wake.
   localparam rcr_row_t ROWS [7] = '{
      '{3'h0, 1'b0, 32'h3, 32'h1E, 1'b1}, '{3'h1, 1'b0, 32'h1, 32'h0F, 1'b1},
      '{3'h1, 1'b1, 32'h0, 32'h1F, 1'b0}, '{3'h4, 1'b1, 32'h2, 32'h1F, 1'b0},
      '{3'h2, 1'b0, 32'h3, 32'h17, 1'b1}, '{3'h2, 1'b1, 32'h2, 32'h17, 1'b1},
      '{3'h3, 1'b0, 32'h3, 32'h1B, 1'b1}};
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [4:0] avs_address_in = 5'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic brownout_in = 1'b0;
   logic master_clear_pin_n_in = 1'b1;
   logic wdt_timeout_in = 1'b0;
   logic reset_instr_in = 1'b0;
   logic interrupt_wake_in = 1'b0;
   logic sleeping_in = 1'b0;
   logic push_in = 1'b0;
   logic pop_in = 1'b0;
   logic [14:0] push_data_in = 15'h0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out, pop_valid_out, jump_out, reset_core_out, irq_out;
   logic instr_done_in, last_rst;
   logic [14:0] pop_data_out, jump_addr_out, pc_in, last_pop, ret;
   int jump_cnt;
   int n_fail = 0;
   int compares = 0;

   always #5 ref_clk_in = ~ref_clk_in;

   rcr_top dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .brownout_in(brownout_in), .master_clear_pin_n_in(master_clear_pin_n_in),
      .wdt_timeout_in(wdt_timeout_in), .reset_instr_in(reset_instr_in),
      .interrupt_wake_in(interrupt_wake_in), .sleeping_in(sleeping_in),
      .instr_done_in(instr_done_in), .pc_in(pc_in), .push_in(push_in), .pop_in(pop_in),
      .push_data_in(push_data_in), .pop_data_out(pop_data_out),
      .pop_valid_out(pop_valid_out), .jump_out(jump_out), .reset_core_out(reset_core_out),
      .jump_addr_out(jump_addr_out), .irq_out(irq_out));
   rcr_core_model core (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .jump_in(jump_out),
      .reset_core_in(reset_core_out), .jump_addr_in(jump_addr_out),
      .pop_valid_in(pop_valid_out), .pop_data_in(pop_data_out),
      .instr_done_out(instr_done_in), .pc_out(pc_in), .last_pop_out(last_pop),
      .last_reset_out(last_rst), .jump_cnt_out(jump_cnt));

   task automatic test_done();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Each bus task starts and ends at a rising edge.
   task automatic bus(input logic wr, input logic [4:0] a, inout logic [31:0] d);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      // The wait ends when waitrequest drops; only the watchdog limits it.
      do begin
         @(posedge ref_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      if (!wr) d = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      logic [31:0] d;
      d = v;
      bus(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] d;
      d = 32'h0;
      bus(1'b0, a, d);
      chk(d, e);
   endtask
   task automatic restore();
      wr(`RCR_OFF_STATUS, 32'h3);
      wr(`RCR_OFF_PCTRL, 32'h1F);
   endtask
   task automatic do_reset();
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      chk({17'h0, jump_addr_out}, {17'h0, `RCR_RESET_ADDR});
      rdchk(`RCR_OFF_STATUS, 32'h3);
      rdchk(`RCR_OFF_PCTRL, 32'h1C);
      rdchk(`RCR_OFF_CTRL, 32'h1);
      rdchk(`RCR_OFF_IRQ_MASK, 32'h0);
      $display("reset test done");
   endtask
   task automatic fire(input rcr_row_t r);
      int base;
      int n;
      logic [14:0] tgt;
      base = jump_cnt;
      n = 0;
      tgt = r.rs ? `RCR_RESET_ADDR : pc_in + 15'h0001;
      sleeping_in <= r.slp;
      @(posedge ref_clk_in);
      case (r.ev)
         3'h0: brownout_in <= 1'b1;
         3'h1: wdt_timeout_in <= 1'b1;
         3'h2: master_clear_pin_n_in <= 1'b0;
         3'h3: reset_instr_in <= 1'b1;
         default: interrupt_wake_in <= 1'b1;
      endcase
      @(posedge ref_clk_in);
      wdt_timeout_in <= 1'b0;
      reset_instr_in <= 1'b0;
      interrupt_wake_in <= 1'b0;
      while (jump_cnt == base && n < 20) begin
         @(posedge ref_clk_in);
         n++;
      end
      if (n >= 20) begin
         n_fail++;
         $display("ERROR %0t no jump seen", $time);
      end
      chk({17'h0, jump_addr_out}, {17'h0, tgt});
      chk({31'h0, last_rst}, {31'h0, r.rs});
      brownout_in <= 1'b0;
      master_clear_pin_n_in <= 1'b1;
      sleeping_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
   endtask
   task automatic stack_case(input logic psh, input int cnt, input logic [31:0] pw,
      input logic rs);
      int base;
      restore();
      base = jump_cnt;
      push_in <= psh;
      pop_in <= !psh;
      repeat (cnt) @(posedge ref_clk_in);
      push_in <= 1'b0;
      pop_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      rdchk(`RCR_OFF_PCTRL, pw);
      chk({31'h0, jump_cnt != base}, {31'h0, rs});
      $display("stack test done");
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_fail++;
      test_done();
   end
   initial begin
      do_reset();
      for (int i = 0; i < 7; i++) begin
         restore();
         fire(ROWS[i]);
         rdchk(`RCR_OFF_STATUS, ROWS[i].st);
         rdchk(`RCR_OFF_PCTRL, ROWS[i].pw);
         $display("event row %0d done", i);
      end
      rdchk(`RCR_OFF_IRQ_ST, 32'h3F);
      chk({31'h0, irq_out}, 32'h0);
      wr(`RCR_OFF_IRQ_MASK, 32'hFF);
      chk({31'h0, irq_out}, 32'h1);
      wr(`RCR_OFF_IRQ_ST, 32'hFF);
      chk({31'h0, irq_out}, 32'h0);
      rdchk(5'h18, 32'h0);
      $display("interrupt and map test done");
      wr(`RCR_OFF_CTRL, 32'h3);
      ret = pc_in + 15'h0001;
      fire('{3'h4, 1'b1, 32'h2, 32'h1F, 1'b0});
      chk({17'h0, jump_addr_out}, {17'h0, `RCR_VECTOR_ADDR});
      stack_case(1'b0, 1, 32'h1F, 1'b0);
      chk({17'h0, last_pop}, {17'h0, ret});
      wr(`RCR_OFF_CTRL, 32'h1);
      push_data_in <= 15'h1ABC;
      stack_case(1'b1, 1, 32'h1F, 1'b0);
      stack_case(1'b0, 1, 32'h1F, 1'b0);
      chk({17'h0, last_pop}, 32'h1ABC);
      stack_case(1'b0, 1, 32'h5F, 1'b1);
      stack_case(1'b1, 17, 32'h9F, 1'b1);
      wr(`RCR_OFF_CTRL, 32'h0);
      stack_case(1'b0, 17, 32'h5F, 1'b0);
      do_reset();
      test_done();
   end
endmodule

// [src/rcr_cfg.svh]
// Offsets, field positions, reset values and fixed addresses of the reset cause recorder.
// Assumes byte addressing on a 32-bit Avalon-MM bus, one register per aligned word.
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH

`define RCR_ADDR_W 5
`define RCR_OFF_STATUS 5'h00
`define RCR_OFF_PCTRL 5'h04
`define RCR_OFF_CTRL 5'h08
`define RCR_OFF_IRQ_ST 5'h0C
`define RCR_OFF_IRQ_MASK 5'h10
`define RCR_OFF_LAST 5'h14

`define RCR_PC_W 15
`define RCR_STACK_DEPTH 16
`define RCR_RESET_ADDR 15'h0000
`define RCR_VECTOR_ADDR 15'h0004

// Status register fields.
`define RCR_ST_PD 0
`define RCR_ST_TO 1

// Power control register fields.
`define RCR_PC_BOR 0
`define RCR_PC_POR 1
`define RCR_PC_RI 2
`define RCR_PC_PIN 3
`define RCR_PC_WDT 4
`define RCR_PC_UNF 6
`define RCR_PC_OVF 7

// Control register fields and reset value.
`define RCR_CT_STACK_ERROR_RESET_ENABLE 0
`define RCR_CT_GIE 1
`define RCR_CTRL_RST 2'h1

// Power-on values of the cause flags; the brown-out flag is undefined, zero is chosen.
`define RCR_RST_OVF 1'h0
`define RCR_RST_UNF 1'h0
`define RCR_RST_WDT 1'h1
`define RCR_RST_PIN 1'h1
`define RCR_RST_RI 1'h1
`define RCR_RST_POR 1'h0
`define RCR_RST_BOR 1'h0
`define RCR_RST_TO 1'h1
`define RCR_RST_PD 1'h1

// Interrupt status bits, one per event.
`define RCR_IRQ_W 8
`define RCR_IQ_BOR 0
`define RCR_IQ_WDT 1
`define RCR_IQ_WWAKE 2
`define RCR_IQ_IWAKE 3
`define RCR_IQ_PIN 4
`define RCR_IQ_RI 5
`define RCR_IQ_OVF 6
`define RCR_IQ_UNF 7

`endif

// [src/rcr_pkg.sv]
// Types shared by the reset cause recorder modules.
// Assumes the constants of rcr_cfg.svh for widths.
package rcr_pkg;

   typedef enum logic [3:0] {
      CAUSE_NONE,
      CAUSE_BOR,
      CAUSE_WDT_RST,
      CAUSE_PIN_RUN,
      CAUSE_PIN_SLEEP,
      CAUSE_RI,
      CAUSE_OVF,
      CAUSE_UNF,
      CAUSE_WDT_WAKE,
      CAUSE_INT_WAKE
   } rcr_cause_t;

   typedef enum logic [1:0] {
      VEC_IDLE,
      VEC_WAIT
   } rcr_vec_state_t;

   typedef struct packed {
      logic ovf;
      logic unf;
      logic wdt_n;
      logic pin_n;
      logic ri_n;
      logic por_n;
      logic bor_n;
      logic to_n;
      logic pd_n;
   } rcr_flags_t;

endpackage

// [src/rcr_stack_if.sv]
// Port bundle between the recorder and its return stack memory.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
interface rcr_stack_if #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
);
   localparam int AW = $clog2(DEPTH);
   logic we;
   logic [AW-1:0] waddr;
   logic [WIDTH-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [WIDTH-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [src/rcr_stack_mem.sv]
// Return stack storage: one write port, one read port with registered data.
// Assumes the controller keeps the write address inside the depth.
`timescale 1ns/100ps
module rcr_stack_mem #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 16
) (
   // Clock.
   input wire logic ref_clk_in,
   // Memory port.
   rcr_stack_if.mem port
);
   logic [WIDTH-1:0] mem_reg [DEPTH];

   always_ff @(posedge ref_clk_in) begin
      if (port.we) begin
         mem_reg[port.waddr] <= port.wdata;
      end
      port.rdata <= mem_reg[port.raddr];
   end
endmodule

// [src/rcr_top.sv]
// Reset cause recorder: keeps the reset cause flags, the return stack and the restart address.
// Assumes pulses from the core and watchdog on ref_clk_in, and asynchronous pin inputs.
`timescale 1ns/100ps
`include "rcr_cfg.svh"

// Overview of operation
// - Every reset or wake updates cause flags.
// - Stack over/underflow flags; optional software reset.
// - Return stack is 16 by 15 bits.
// - Power-on sets defaults, restarts at zero.
// - Watchdog wake clears timeout, power-down; resumes.
// - Interrupt wake sets timeout, clears power-down; resumes.
// - Pin reset running clears pin flag only.
// - Pin reset sleeping: pin, timeout, power-down.
// - Overflow reset sets overflow, restarts at zero.
// - Underflow reset sets underflow, restarts at zero.
// - Enabled interrupt wake later vectors to 0004h.
// - Flags not named by event stay unchanged.
module rcr_top #(
   parameter int WIDTH = `RCR_PC_W,
   parameter int DEPTH = `RCR_STACK_DEPTH
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Avalon-MM slave.
   input wire logic [`RCR_ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Reset and wake sources.
   input wire logic brownout_in,
   input wire logic master_clear_pin_n_in,
   input wire logic wdt_timeout_in,
   input wire logic reset_instr_in,
   input wire logic interrupt_wake_in,
   // Processor core.
   input wire logic sleeping_in,
   input wire logic instr_done_in,
   input wire logic [WIDTH-1:0] pc_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [WIDTH-1:0] push_data_in,
   output logic [WIDTH-1:0] pop_data_out,
   output logic pop_valid_out,
   output logic jump_out,
   output logic reset_core_out,
   output logic [WIDTH-1:0] jump_addr_out,
   // Interrupt.
   output logic irq_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   rcr_stack_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) stk ();

   rcr_stack_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
      .ref_clk_in(ref_clk_in),
      .port(stk.mem)
   );

   // Pin synchronisers and edge history.
   logic [1:0] bor_sync_reg;
   logic [1:0] pin_sync_reg;
   logic bor_old_reg;
   logic pin_old_reg;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         bor_sync_reg <= 2'h0;
         pin_sync_reg <= 2'h3;
         bor_old_reg <= 1'h0;
         pin_old_reg <= 1'h1;
      end else begin
         bor_sync_reg <= {bor_sync_reg[0], brownout_in};
         pin_sync_reg <= {pin_sync_reg[0], master_clear_pin_n_in};
         bor_old_reg <= bor_sync_reg[1];
         pin_old_reg <= pin_sync_reg[1];
      end
   end

   // Event decode.
   logic [CW-1:0] count_reg;
   logic [1:0] ctrl_reg;
   wire stack_error_reset_enable = ctrl_reg[`RCR_CT_STACK_ERROR_RESET_ENABLE];
   wire global_interrupt_enable = ctrl_reg[`RCR_CT_GIE];
   wire bor_evt = bor_sync_reg[1] & ~bor_old_reg;
   wire pin_evt = ~pin_sync_reg[1] & pin_old_reg;
   wire wdt_rst_evt = wdt_timeout_in & ~sleeping_in;
   wire wdt_wake_evt = wdt_timeout_in & sleeping_in;
   wire int_wake_evt = interrupt_wake_in & sleeping_in;
   wire pin_run_evt = pin_evt & ~sleeping_in;
   wire pin_sleep_evt = pin_evt & sleeping_in;
   wire full = count_reg == CW'(DEPTH);
   wire empty = count_reg == '0;

   // Vector sequencer signals.
   rcr_pkg::rcr_vec_state_t vec_reg;
   rcr_pkg::rcr_vec_state_t vec_next;
   wire vec_push = (vec_reg == rcr_pkg::VEC_WAIT) & instr_done_in;
   wire any_push = push_in | vec_push;
   wire ovf_evt = any_push & full;
   wire unf_evt = pop_in & ~any_push & empty;
   wire stk_wr = any_push & ~full;
   wire stk_rd = pop_in & ~any_push & ~empty;

   // Highest priority cause of this cycle.
   rcr_pkg::rcr_cause_t cause;
   assign cause = bor_evt ? rcr_pkg::CAUSE_BOR :
                  wdt_rst_evt ? rcr_pkg::CAUSE_WDT_RST :
                  pin_run_evt ? rcr_pkg::CAUSE_PIN_RUN :
                  pin_sleep_evt ? rcr_pkg::CAUSE_PIN_SLEEP :
                  reset_instr_in ? rcr_pkg::CAUSE_RI :
                  (ovf_evt & stack_error_reset_enable) ? rcr_pkg::CAUSE_OVF :
                  (unf_evt & stack_error_reset_enable) ? rcr_pkg::CAUSE_UNF :
                  wdt_wake_evt ? rcr_pkg::CAUSE_WDT_WAKE :
                  int_wake_evt ? rcr_pkg::CAUSE_INT_WAKE :
                  rcr_pkg::CAUSE_NONE;
   wire is_wake = (cause == rcr_pkg::CAUSE_WDT_WAKE) | (cause == rcr_pkg::CAUSE_INT_WAKE);
   wire is_reset = (cause != rcr_pkg::CAUSE_NONE) & ~is_wake;

   // Stack pointer and memory port.
   logic [CW-1:0] count_next;
   assign count_next = stk_wr ? count_reg + CW'(1) :
                       stk_rd ? count_reg - CW'(1) : count_reg;
   assign stk.we = stk_wr;
   assign stk.waddr = count_reg[AW-1:0];
   assign stk.wdata = vec_push ? pc_in : push_data_in;
   assign stk.raddr = AW'(count_reg - CW'(1));

   // Bus access decode; every access waits exactly one cycle.
   logic ack_reg;
   wire req = avs_read_in | avs_write_in;
   wire done = req & ack_reg;
   wire wr = avs_write_in & done;
   wire sel_st = avs_address_in == `RCR_OFF_STATUS;
   wire sel_pc = avs_address_in == `RCR_OFF_PCTRL;
   wire sel_ct = avs_address_in == `RCR_OFF_CTRL;
   wire sel_iq = avs_address_in == `RCR_OFF_IRQ_ST;
   wire sel_mk = avs_address_in == `RCR_OFF_IRQ_MASK;
   wire sel_ls = avs_address_in == `RCR_OFF_LAST;
   assign avs_waitrequest_out = req & ~ack_reg;

   // Cause flags.
   rcr_pkg::rcr_flags_t flags_reg;
   rcr_pkg::rcr_flags_t flags_next;
   rcr_pkg::rcr_flags_t flags_rst;
   assign flags_rst = '{ovf: `RCR_RST_OVF, unf: `RCR_RST_UNF, wdt_n: `RCR_RST_WDT,
                        pin_n: `RCR_RST_PIN, ri_n: `RCR_RST_RI, por_n: `RCR_RST_POR,
                        bor_n: `RCR_RST_BOR, to_n: `RCR_RST_TO, pd_n: `RCR_RST_PD};

   // Software writes first, hardware events afterwards so that an event wins.
   always_comb begin
      flags_next = flags_reg;
      if (wr & sel_st) begin
         flags_next.to_n = avs_writedata_in[`RCR_ST_TO];
         flags_next.pd_n = avs_writedata_in[`RCR_ST_PD];
      end
      if (wr & sel_pc) begin
         flags_next.ovf = avs_writedata_in[`RCR_PC_OVF];
         flags_next.unf = avs_writedata_in[`RCR_PC_UNF];
         flags_next.wdt_n = avs_writedata_in[`RCR_PC_WDT];
         flags_next.pin_n = avs_writedata_in[`RCR_PC_PIN];
         flags_next.ri_n = avs_writedata_in[`RCR_PC_RI];
         flags_next.por_n = avs_writedata_in[`RCR_PC_POR];
         flags_next.bor_n = avs_writedata_in[`RCR_PC_BOR];
      end
      if (ovf_evt) begin
         flags_next.ovf = 1'h1;
      end
      if (unf_evt) begin
         flags_next.unf = 1'h1;
      end
      // Fields a cause does not name are left as they are.
      case (cause)
         rcr_pkg::CAUSE_BOR: begin
            flags_next.ovf = 1'h0;
            flags_next.unf = 1'h0;
            flags_next.pin_n = 1'h1;
            flags_next.ri_n = 1'h1;
            flags_next.bor_n = 1'h0;
            flags_next.to_n = 1'h1;
            flags_next.pd_n = 1'h1;
         end
         rcr_pkg::CAUSE_WDT_RST: begin
            flags_next.wdt_n = 1'h0;
            flags_next.to_n = 1'h0;
         end
         rcr_pkg::CAUSE_PIN_RUN: begin
            flags_next.pin_n = 1'h0;
         end
         rcr_pkg::CAUSE_PIN_SLEEP: begin
            flags_next.pin_n = 1'h0;
            flags_next.to_n = 1'h1;
            flags_next.pd_n = 1'h0;
         end
         rcr_pkg::CAUSE_RI: begin
            flags_next.ri_n = 1'h0;
         end
         rcr_pkg::CAUSE_OVF: begin
            flags_next.ovf = 1'h1;
         end
         rcr_pkg::CAUSE_UNF: begin
            flags_next.unf = 1'h1;
         end
         rcr_pkg::CAUSE_WDT_WAKE: begin
            flags_next.to_n = 1'h0;
            flags_next.pd_n = 1'h0;
         end
         rcr_pkg::CAUSE_INT_WAKE: begin
            flags_next.to_n = 1'h1;
            flags_next.pd_n = 1'h0;
         end
         default: begin
         end
      endcase
   end

   // Interrupt status: sticky, write one to clear, a new event wins.
   logic [`RCR_IRQ_W-1:0] irq_st_reg;
   logic [`RCR_IRQ_W-1:0] irq_mask_reg;
   logic [`RCR_IRQ_W-1:0] irq_set;
   logic [`RCR_IRQ_W-1:0] irq_clr;
   assign irq_set[`RCR_IQ_BOR] = cause == rcr_pkg::CAUSE_BOR;
   assign irq_set[`RCR_IQ_WDT] = cause == rcr_pkg::CAUSE_WDT_RST;
   assign irq_set[`RCR_IQ_WWAKE] = cause == rcr_pkg::CAUSE_WDT_WAKE;
   assign irq_set[`RCR_IQ_IWAKE] = cause == rcr_pkg::CAUSE_INT_WAKE;
   assign irq_set[`RCR_IQ_PIN] = pin_run_evt | pin_sleep_evt;
   assign irq_set[`RCR_IQ_RI] = cause == rcr_pkg::CAUSE_RI;
   assign irq_set[`RCR_IQ_OVF] = ovf_evt;
   assign irq_set[`RCR_IQ_UNF] = unf_evt;
   assign irq_clr = (wr & sel_iq) ? avs_writedata_in[`RCR_IRQ_W-1:0] : '0;
   assign irq_out = |(irq_st_reg & irq_mask_reg);

   // Vector sequencer: an enabled interrupt wake pushes the return address
   // after the next instruction and branches to the vector.
   always_comb begin
      vec_next = vec_reg;
      case (vec_reg)
         rcr_pkg::VEC_IDLE: begin
            if ((cause == rcr_pkg::CAUSE_INT_WAKE) & global_interrupt_enable) begin
               vec_next = rcr_pkg::VEC_WAIT;
            end
         end
         rcr_pkg::VEC_WAIT: begin
            if (is_reset | instr_done_in) begin
               vec_next = rcr_pkg::VEC_IDLE;
            end
         end
         default: begin
            vec_next = rcr_pkg::VEC_IDLE;
         end
      endcase
   end

   // Jump target of this cycle.
   wire vec_jump = vec_push & ~is_reset;
   logic [WIDTH-1:0] jump_addr_next;
   assign jump_addr_next = is_reset ? `RCR_RESET_ADDR :
                           is_wake ? pc_in + WIDTH'(1) :
                           vec_jump ? `RCR_VECTOR_ADDR :
                           jump_addr_out;

   // Last cause and target kept for software.
   rcr_pkg::rcr_cause_t last_cause_reg;

   // Read data selection.
   wire [31:0] rd_st = {30'h0, flags_reg.to_n, flags_reg.pd_n};
   wire [31:0] rd_pc = {24'h0, flags_reg.ovf, flags_reg.unf, 1'h0, flags_reg.wdt_n,
                        flags_reg.pin_n, flags_reg.ri_n, flags_reg.por_n, flags_reg.bor_n};
   wire [31:0] rd_ct = {30'h0, ctrl_reg};
   wire [31:0] rd_iq = {24'h0, irq_st_reg};
   wire [31:0] rd_mk = {24'h0, irq_mask_reg};
   wire [31:0] rd_ls = {12'h0, last_cause_reg, 1'h0, jump_addr_out};
   wire [31:0] rd_data = sel_st ? rd_st :
                         sel_pc ? rd_pc :
                         sel_ct ? rd_ct :
                         sel_iq ? rd_iq :
                         sel_mk ? rd_mk :
                         sel_ls ? rd_ls : 32'h0;

   // Bus handshake and read data.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ack_reg <= 1'h0;
         avs_readdata_out <= 32'h0;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (avs_read_in & ~ack_reg) begin
            avs_readdata_out <= rd_data;
         end
      end
   end

   // Control and interrupt registers.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= `RCR_CTRL_RST;
         irq_mask_reg <= '0;
         irq_st_reg <= '0;
      end else begin
         if (wr & sel_ct) begin
            ctrl_reg <= avs_writedata_in[1:0];
         end
         if (wr & sel_mk) begin
            irq_mask_reg <= avs_writedata_in[`RCR_IRQ_W-1:0];
         end
         irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
      end
   end

   // Power-on values come from the synchronous reset.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         flags_reg <= flags_rst;
         count_reg <= '0;
         vec_reg <= rcr_pkg::VEC_IDLE;
      end else begin
         flags_reg <= flags_next;
         count_reg <= count_next;
         vec_reg <= vec_next;
      end
   end

   // Restart and resume outputs.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         jump_out <= 1'h1;
         reset_core_out <= 1'h1;
         jump_addr_out <= `RCR_RESET_ADDR;
         last_cause_reg <= rcr_pkg::CAUSE_NONE;
      end else begin
         jump_out <= is_reset | is_wake | vec_jump;
         reset_core_out <= is_reset;
         jump_addr_out <= jump_addr_next;
         if (cause != rcr_pkg::CAUSE_NONE) begin
            last_cause_reg <= cause;
         end
      end
   end

   // Pop data: the memory read register holds the top entry one edge after the pop.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pop_valid_out <= 1'h0;
      end else begin
         pop_valid_out <= stk_rd;
      end
   end
   assign pop_data_out = stk.rdata;

endmodule
